// ---- src/bsmc_top.sv ----
// byte steering and machine control flags block
//
// Contract
// - byte operations use only the low 16 bits of A, B and S
// - byte load takes A 16:23 if address bit 31 zero, else B 24:31
// - both byte load forms zero the upper 24 destination bits
// - register byte load always takes B 24:31
// - byte store steers by address bit 31, destination 0:15 zeroed
// - register byte store: B 16:23 and A 24:31, upper half zeroed
// - byte swap exchanges the two low bytes of B, upper half zeroed
// - sense copies flags to destination, bits 12:15 to condition bus and micro flags
// - flag 04 shows float unit fitted, flag 05 check assist fitted
// - flag 06 follows the panel initialise switch
// - flag 07 sets on single step switch, clears on any other switch
// - flag 09 carries the automatic restart strap
// - flag 10 sets on panel function select, clears when panel addressed
// - flag 11 sets when an addressed module fails to respond in time
// - flags 13 and 14 report memory malfunction
// - flag 15 reports early power warning, lowest micro flag on sense
// - clear operation zeroes flags where second operand bit is one
// - strapped flags are untouched by the clear operation
// - load wait copies B bit 16 into the wait latch and lamp
`timescale 1ns/1ps
module bsmc_top
	import bsmc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              op_valid,
	input  wire bsmc_op_type       op_code,
	input  wire logic [DATA_W-1:0] a_bus,
	input  wire logic [DATA_W-1:0] b_bus,
	input  wire logic              memory_address_reg_bit31,
	input  wire logic              float_unit_present,
	input  wire logic              check_assist_present,
	input  wire logic              auto_restart_strap,
	input  wire logic              init_switch,
	input  wire logic              single_step_switch,
	input  wire logic              other_function_switch,
	input  wire logic              panel_function_select,
	input  wire logic              panel_addressed,
	input  wire logic              module_response_timeout,
	input  wire logic [1:0]        memory_malfunction,
	input  wire logic              early_power_warning,
	output logic      [DATA_W-1:0] s_bus_r,
	output logic                   s_valid_r,
	output logic      [CC_W-1:0]   condition_flag_bus_r,
	output logic      [CC_W-1:0]   micro_flags_r,
	output logic                   wait_lamp_r
);

	// ----------------------------------------
	// byte steering
	// ----------------------------------------
	function automatic logic [HALF_W-1:0] steer_half(
		input bsmc_op_type         op,
		input logic [HALF_W-1:0]   a16,
		input logic [HALF_W-1:0]   b16,
		input logic                ma31
	);
		logic [BYTE_W-1:0] a_hi;
		logic [BYTE_W-1:0] a_lo;
		logic [BYTE_W-1:0] b_hi;
		logic [BYTE_W-1:0] b_lo;
		logic [HALF_W-1:0] res;
		a_hi = a16[HALF_W-1:BYTE_W];
		a_lo = a16[BYTE_W-1:0];
		b_hi = b16[HALF_W-1:BYTE_W];
		b_lo = b16[BYTE_W-1:0];
		res  = HALF_ZERO;
		unique case (op)
			BSMC_BYTE_LOAD: begin
				res = ma31 ? {8'h00, b_lo} : {8'h00, a_hi};
			end
			BSMC_BYTE_LOAD_REG_FORM: begin
				res = {8'h00, b_lo};
			end
			BSMC_BYTE_STORE: begin
				res = ma31 ? {b_hi, a_lo} : {a_lo, b_lo};
			end
			BSMC_BYTE_STORE_REG_FORM: begin
				res = {b_hi, a_lo};
			end
			BSMC_BYTE_SWAP: begin
				res = {b_lo, b_hi};
			end
			default: begin
				res = HALF_ZERO;
			end
		endcase
		return res;
	endfunction

	function automatic logic is_sense(input bsmc_op_type op);
		return (op == BSMC_SENSE_CONTROL_FLAGS) || (op == BSMC_SENSE_CONTROL_FLAGS_JUMP);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;

	assign pin_raw[PIN_FLOAT]   = float_unit_present;
	assign pin_raw[PIN_CRC]     = check_assist_present;
	assign pin_raw[PIN_RESTART] = auto_restart_strap;
	assign pin_raw[PIN_INIT]    = init_switch;
	assign pin_raw[PIN_STEP]    = single_step_switch;
	assign pin_raw[PIN_OTHER]   = other_function_switch;
	assign pin_raw[PIN_SELECT]  = panel_function_select;
	assign pin_raw[PIN_ADDRESS] = panel_addressed;
	assign pin_raw[PIN_TIMEOUT] = module_response_timeout;
	assign pin_raw[PIN_MEM_HI]  = memory_malfunction[1];
	assign pin_raw[PIN_MEM_LO]  = memory_malfunction[0];
	assign pin_raw[PIN_POWER]   = early_power_warning;

	bsmc_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (pin_raw),
		.pin_sync (pin_sync)
	);

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	logic op_clear;
	logic op_sense;
	logic op_wait;
	logic op_byte;

	assign op_clear = op_valid && (op_code == BSMC_CLEAR_CONTROL_FLAGS);
	assign op_sense = op_valid && is_sense(op_code);
	assign op_wait  = op_valid && (op_code == BSMC_LOAD_WAIT_LATCH);
	assign op_byte  = op_valid && !op_clear && !op_sense && !op_wait && (op_code != BSMC_NONE);

	// ----------------------------------------
	// straps and live levels
	// ----------------------------------------
	logic [MCR_W-1:0] strap_r;
	logic             init_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			strap_r <= MCR_RESET;
		end else begin
			strap_r                <= MCR_RESET;
			strap_r[MCF_FLOAT]     <= pin_sync[PIN_FLOAT];
			strap_r[MCF_CRC]       <= pin_sync[PIN_CRC];
			strap_r[MCF_RESTART]   <= pin_sync[PIN_RESTART];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			init_r <= 1'b0;
		end else begin
			init_r <= pin_sync[PIN_INIT];
		end
	end

	// ----------------------------------------
	// sticky flags
	// ----------------------------------------
	logic [MCR_W-1:0] sticky_r;
	logic [MCR_W-1:0] sticky_nxt;
	logic [MCR_W-1:0] set_vec;
	logic [MCR_W-1:0] clr_vec;

	always_comb begin
		set_vec = MCR_RESET;
		clr_vec = MCR_RESET;
		set_vec[MCF_STEP]    = pin_sync[PIN_STEP];
		clr_vec[MCF_STEP]    = pin_sync[PIN_OTHER];
		set_vec[MCF_ATTN]    = pin_sync[PIN_SELECT];
		clr_vec[MCF_ATTN]    = pin_sync[PIN_ADDRESS];
		set_vec[MCF_TIMEOUT] = pin_sync[PIN_TIMEOUT];
		set_vec[MCF_MEM_HI]  = pin_sync[PIN_MEM_HI];
		set_vec[MCF_MEM_LO]  = pin_sync[PIN_MEM_LO];
		set_vec[MCF_POWER]   = pin_sync[PIN_POWER];
		if (op_clear) begin
			clr_vec = clr_vec | b_bus[MCR_W-1:0];
		end
		// straps never clear, set wins over clear
		sticky_nxt = ((sticky_r & ~clr_vec) | set_vec) & MCR_STICKY_MASK;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sticky_r <= MCR_RESET;
		end else begin
			sticky_r <= sticky_nxt;
		end
	end

	// ----------------------------------------
	// flag view
	// ----------------------------------------
	logic [MCR_W-1:0] mcr_view;

	assign mcr_view = (strap_r | sticky_r | ({{(MCR_W-1){1'b0}}, init_r} << MCF_INIT)) & MCR_READ_MASK;

	// ----------------------------------------
	// destination bus
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_bus_r   <= WORD_ZERO;
			s_valid_r <= 1'b0;
		end else begin
			s_valid_r <= op_valid && (op_code != BSMC_NONE);
			if (op_sense) begin
				s_bus_r <= {HALF_ZERO, mcr_view};
			end else if (op_byte) begin
				s_bus_r <= {HALF_ZERO, steer_half(op_code, a_bus[HALF_W-1:0], b_bus[HALF_W-1:0],
					memory_address_reg_bit31)};
			end else begin
				s_bus_r <= WORD_ZERO;
			end
		end
	end

	// ----------------------------------------
	// condition bus and micro flags
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			condition_flag_bus_r <= CC_ZERO;
			micro_flags_r        <= CC_ZERO;
		end else begin
			if (op_sense) begin
				condition_flag_bus_r <= mcr_view[CC_W-1:0];
				micro_flags_r        <= mcr_view[CC_W-1:0];
			end else begin
				condition_flag_bus_r <= CC_ZERO;
			end
		end
	end

	// ----------------------------------------
	// wait latch
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wait_lamp_r <= 1'b0;
		end else if (op_wait) begin
			wait_lamp_r <= b_bus[WAIT_BIT];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_load_steer;
		@(posedge core_clk) disable iff (rst)
		(op_valid && op_code == BSMC_BYTE_LOAD) |=>
			s_bus_r == {24'h000000, ($past(memory_address_reg_bit31) ? $past(b_bus[7:0]) : $past(a_bus[15:8]))};
	endproperty
	a_load_steer: assert property (p_load_steer) else $error("byte load steering wrong");

	property p_load_upper_zero;
		@(posedge core_clk) disable iff (rst)
		(op_valid && (op_code == BSMC_BYTE_LOAD || op_code == BSMC_BYTE_LOAD_REG_FORM)) |=>
			(s_bus_r[31:8] == 24'h000000) && s_valid_r;
	endproperty
	a_load_upper_zero: assert property (p_load_upper_zero) else $error("byte load upper bits not zero");

	property p_load_reg;
		@(posedge core_clk) disable iff (rst)
		(op_valid && op_code == BSMC_BYTE_LOAD_REG_FORM) |=> s_bus_r[7:0] == $past(b_bus[7:0]);
	endproperty
	a_load_reg: assert property (p_load_reg) else $error("register byte load wrong");

	property p_store_steer;
		@(posedge core_clk) disable iff (rst)
		(op_valid && op_code == BSMC_BYTE_STORE) |=> s_bus_r == {16'h0000,
			($past(memory_address_reg_bit31) ? {$past(b_bus[15:8]), $past(a_bus[7:0])}
			: {$past(a_bus[7:0]), $past(b_bus[7:0])})};
	endproperty
	a_store_steer: assert property (p_store_steer) else $error("byte store steering wrong");

	property p_store_reg;
		@(posedge core_clk) disable iff (rst)
		(op_valid && op_code == BSMC_BYTE_STORE_REG_FORM) |=>
			s_bus_r == {16'h0000, $past(b_bus[15:8]), $past(a_bus[7:0])};
	endproperty
	a_store_reg: assert property (p_store_reg) else $error("register byte store wrong");

	property p_swap;
		@(posedge core_clk) disable iff (rst)
		(op_valid && op_code == BSMC_BYTE_SWAP) |=> s_bus_r == {16'h0000, $past(b_bus[7:0]), $past(b_bus[15:8])};
	endproperty
	a_swap: assert property (p_swap) else $error("byte swap wrong");

	property p_sense;
		@(posedge core_clk) disable iff (rst)
		(op_valid && is_sense(op_code)) |=>
			(condition_flag_bus_r == s_bus_r[3:0]) && (micro_flags_r == s_bus_r[3:0]) && s_bus_r[31:16] == 16'h0000;
	endproperty
	a_sense: assert property (p_sense) else $error("sense flags mismatch");

	property p_step_hold;
		@(posedge core_clk) disable iff (rst)
		(sticky_r[MCF_STEP] && !pin_sync[PIN_OTHER] && !op_clear) |=> sticky_r[MCF_STEP];
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("single step flag dropped");

	property p_attn_set;
		@(posedge core_clk) disable iff (rst)
		pin_sync[PIN_SELECT] |=> sticky_r[MCF_ATTN];
	endproperty
	a_attn_set: assert property (p_attn_set) else $error("attention flag not set");

	property p_clear;
		@(posedge core_clk) disable iff (rst)
		(op_clear && b_bus[MCF_TIMEOUT] && !pin_sync[PIN_TIMEOUT]) |=> !sticky_r[MCF_TIMEOUT];
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not zero flag");

	property p_strap_keep;
		@(posedge core_clk) disable iff (rst)
		op_clear |=> strap_r == $past(strap_r) || $past(pin_sync) != $past(pin_sync, 2);
	endproperty
	a_strap_keep: assert property (p_strap_keep) else $error("strap altered by clear");

	property p_wait;
		@(posedge core_clk) disable iff (rst)
		op_wait |=> wait_lamp_r == $past(b_bus[WAIT_BIT]) ##1 ($past(op_wait) || $stable(wait_lamp_r));
	endproperty
	a_wait: assert property (p_wait) else $error("wait latch wrong");

	property p_zero_bits;
		@(posedge core_clk) disable iff (rst)
		op_sense |=> s_bus_r[15:12] == 4'h0 && !s_bus_r[7] && !s_bus_r[3];
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("spare flag bits not zero");

	c_load_high: cover property (@(posedge core_clk) disable iff (rst)
		op_valid && op_code == BSMC_BYTE_LOAD && memory_address_reg_bit31);
	c_sense_power: cover property (@(posedge core_clk) disable iff (rst)
		op_sense && mcr_view[MCF_POWER]);
	c_clear_attn: cover property (@(posedge core_clk) disable iff (rst)
		op_clear && sticky_r[MCF_ATTN] ##1 !sticky_r[MCF_ATTN]);
	c_wait_on: cover property (@(posedge core_clk) disable iff (rst)
		op_wait ##1 wait_lamp_r);

endmodule

// ---- src/bsmc_pkg.sv ----
// package: constants and types for byte steering and machine control
package bsmc_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BYTE_W = 8;
	localparam int MCR_W  = 16;
	localparam int CC_W   = 4;

	// ----------------------------------------
	// control flag positions (flag n sits at index 15-n)
	// ----------------------------------------
	localparam int MCF_FLOAT   = 11;
	localparam int MCF_CRC     = 10;
	localparam int MCF_INIT    = 9;
	localparam int MCF_STEP    = 8;
	localparam int MCF_RESTART = 6;
	localparam int MCF_ATTN    = 5;
	localparam int MCF_TIMEOUT = 4;
	localparam int MCF_MEM_HI  = 2;
	localparam int MCF_MEM_LO  = 1;
	localparam int MCF_POWER   = 0;

	// ----------------------------------------
	// masks and reset values
	// ----------------------------------------
	localparam logic [MCR_W-1:0]  MCR_RESET       = 16'h0000;
	localparam logic [MCR_W-1:0]  MCR_STRAP_MASK  = 16'h0c40;
	localparam logic [MCR_W-1:0]  MCR_STICKY_MASK = 16'h0137;
	localparam logic [MCR_W-1:0]  MCR_READ_MASK   = 16'h0f77;
	localparam logic [DATA_W-1:0] WORD_ZERO       = 32'h0000_0000;
	localparam logic [HALF_W-1:0] HALF_ZERO       = 16'h0000;
	localparam logic [CC_W-1:0]   CC_ZERO         = 4'h0;

	// second-operand bit 16 drives the wait latch
	localparam int WAIT_BIT = 15;

	// ----------------------------------------
	// synchronised pin vector layout
	// ----------------------------------------
	localparam int PIN_W        = 12;
	localparam int PIN_FLOAT    = 0;
	localparam int PIN_CRC      = 1;
	localparam int PIN_RESTART  = 2;
	localparam int PIN_INIT     = 3;
	localparam int PIN_STEP     = 4;
	localparam int PIN_OTHER    = 5;
	localparam int PIN_SELECT   = 6;
	localparam int PIN_ADDRESS  = 7;
	localparam int PIN_TIMEOUT  = 8;
	localparam int PIN_MEM_HI   = 9;
	localparam int PIN_MEM_LO   = 10;
	localparam int PIN_POWER    = 11;

	// ----------------------------------------
	// micro operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		BSMC_NONE,
		BSMC_BYTE_LOAD,
		BSMC_BYTE_LOAD_REG_FORM,
		BSMC_BYTE_STORE,
		BSMC_BYTE_STORE_REG_FORM,
		BSMC_BYTE_SWAP,
		BSMC_SENSE_CONTROL_FLAGS,
		BSMC_SENSE_CONTROL_FLAGS_JUMP,
		BSMC_CLEAR_CONTROL_FLAGS,
		BSMC_LOAD_WAIT_LATCH
	} bsmc_op_type;

endpackage

// ---- src/bsmc_sync.sv ----
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module bsmc_sync
	import bsmc_pkg::*;
#(
	parameter int WIDTH = PIN_W
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	// ----------------------------------------
	// stages
	// ----------------------------------------
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= pin_in;
			stage2_r <= stage1_r;
		end
	end

	assign pin_sync = stage2_r;

endmodule

// ---- tb/bsmc_seq_model.sv ----
// sequencer model that drives the operation strobe and the operand buses
`timescale 1ns/1ps
module bsmc_seq_model
	import bsmc_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              req_valid,
	input  wire bsmc_op_type       req_op,
	input  wire logic [DATA_W-1:0] req_a,
	input  wire logic [DATA_W-1:0] req_b,
	input  wire logic              req_ma,
	output logic                   op_valid,
	output bsmc_op_type            op_code,
	output logic      [DATA_W-1:0] a_bus,
	output logic      [DATA_W-1:0] b_bus,
	output logic                   memory_address_reg_bit31
);
	logic [DATA_W-1:0] idle_r;

	// ----------------------------------------
	// released A bus shows the inverse of its last value, B bus the last A value
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			idle_r <= 32'h5a5a_a5a5;
		end else begin
			idle_r <= ~a_bus;
		end
	end

	// ----------------------------------------
	// request passes straight onto the buses
	// ----------------------------------------
	always_comb begin
		op_valid                 = req_valid;
		op_code                  = req_valid ? req_op : BSMC_SENSE_CONTROL_FLAGS;
		a_bus                    = req_valid ? req_a : idle_r;
		b_bus                    = req_valid ? req_b : ~idle_r;
		memory_address_reg_bit31 = req_valid ? req_ma : idle_r[0];
	end
endmodule

// ---- tb/test_bsmc_top.sv ----
// self-checking testbench for the byte steering and machine control block
`timescale 1ns/1ps
module test_bsmc_top
	import bsmc_pkg::*;
;
	logic              core_clk;
	logic              rst;
	logic              req_v;
	bsmc_op_type       req_op;
	logic [DATA_W-1:0] req_a;
	logic [DATA_W-1:0] req_b;
	logic              req_ma;
	logic              op_valid;
	bsmc_op_type       op_code;
	logic [DATA_W-1:0] a_bus;
	logic [DATA_W-1:0] b_bus;
	logic              ma31;
	logic [PIN_W-1:0]  pins;
	logic [PIN_W-1:0]  pin_next;
	logic [DATA_W-1:0] s_bus_r;
	logic              s_valid_r;
	logic [CC_W-1:0]   condition_flag_bus_r;
	logic [CC_W-1:0]   micro_flags_r;
	logic              wait_lamp_r;
	logic [MCR_W-1:0]  sticky_q;
	logic [DATA_W-1:0] e_s;
	logic              e_valid;
	logic [CC_W-1:0]   e_cc;
	logic [CC_W-1:0]   e_micro;
	logic              e_wait;
	int                error_cnt;
	int                tests_run;

	bsmc_seq_model u_seq (.core_clk(core_clk), .rst(rst), .req_valid(req_v), .req_op(req_op), .req_a(req_a),
		.req_b(req_b), .req_ma(req_ma), .op_valid(op_valid), .op_code(op_code), .a_bus(a_bus), .b_bus(b_bus),
		.memory_address_reg_bit31(ma31));

	bsmc_top DUT (.core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .a_bus(a_bus),
		.b_bus(b_bus), .memory_address_reg_bit31(ma31), .float_unit_present(pins[PIN_FLOAT]),
		.check_assist_present(pins[PIN_CRC]), .auto_restart_strap(pins[PIN_RESTART]),
		.init_switch(pins[PIN_INIT]), .single_step_switch(pins[PIN_STEP]),
		.other_function_switch(pins[PIN_OTHER]), .panel_function_select(pins[PIN_SELECT]),
		.panel_addressed(pins[PIN_ADDRESS]), .module_response_timeout(pins[PIN_TIMEOUT]),
		.memory_malfunction({pins[PIN_MEM_HI], pins[PIN_MEM_LO]}), .early_power_warning(pins[PIN_POWER]),
		.s_bus_r(s_bus_r), .s_valid_r(s_valid_r), .condition_flag_bus_r(condition_flag_bus_r),
		.micro_flags_r(micro_flags_r), .wait_lamp_r(wait_lamp_r));

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic [MCR_W-1:0] exp_flags();
		logic [MCR_W-1:0] f;
		f              = sticky_q;
		f[MCF_FLOAT]   = pins[PIN_FLOAT];
		f[MCF_CRC]     = pins[PIN_CRC];
		f[MCF_INIT]    = pins[PIN_INIT];
		f[MCF_RESTART] = pins[PIN_RESTART];
		return f;
	endfunction

	function automatic logic [DATA_W-1:0] exp_data(bsmc_op_type op, logic [DATA_W-1:0] a, logic [DATA_W-1:0] b,
		logic ma);
		case (op)
			BSMC_BYTE_LOAD:                return {24'h000000, ma ? b[7:0] : a[15:8]};
			BSMC_BYTE_LOAD_REG_FORM:       return {24'h000000, b[7:0]};
			BSMC_BYTE_STORE:               return {HALF_ZERO, ma ? {b[15:8], a[7:0]} : {a[7:0], b[7:0]}};
			BSMC_BYTE_STORE_REG_FORM:      return {HALF_ZERO, b[15:8], a[7:0]};
			BSMC_BYTE_SWAP:                return {HALF_ZERO, b[7:0], b[15:8]};
			BSMC_SENSE_CONTROL_FLAGS,
			BSMC_SENSE_CONTROL_FLAGS_JUMP: return {HALF_ZERO, exp_flags()};
			default:                       return WORD_ZERO;
		endcase
	endfunction

	task automatic check(logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp, string what);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// one request per cycle, previous answer checked
	// ----------------------------------------
	task automatic step(logic v, bsmc_op_type op, logic [DATA_W-1:0] a, logic [DATA_W-1:0] b, logic ma);
		@(posedge core_clk);
		req_v  <= v;
		req_op <= op;
		req_a  <= a;
		req_b  <= b;
		req_ma <= ma;
		pins   <= pin_next;
		#1;
		check(32'(s_valid_r), 32'(e_valid), "valid");
		check(s_bus_r, e_s, "dest");
		check(32'(condition_flag_bus_r), 32'(e_cc), "cond");
		check(32'(micro_flags_r), 32'(e_micro), "micro");
		check(32'(wait_lamp_r), 32'(e_wait), "wait");
		e_valid = v && op != BSMC_NONE;
		e_s     = v ? exp_data(op, a, b, ma) : WORD_ZERO;
		e_cc    = CC_ZERO;
		if (v && (op == BSMC_SENSE_CONTROL_FLAGS || op == BSMC_SENSE_CONTROL_FLAGS_JUMP)) begin
			e_cc    = e_s[3:0];
			e_micro = e_s[3:0];
		end
		// clear mask and strap immunity
		if (v && op == BSMC_CLEAR_CONTROL_FLAGS)
			sticky_q = sticky_q & ~b[15:0];
		if (v && op == BSMC_LOAD_WAIT_LATCH)
			e_wait = b[WAIT_BIT];
	endtask

	task automatic idle(int n);
		repeat (n) step(1'b0, BSMC_NONE, WORD_ZERO, WORD_ZERO, 1'b0);
	endtask

	task automatic sense();
		step(1'b1, BSMC_SENSE_CONTROL_FLAGS, WORD_ZERO, WORD_ZERO, 1'b0);
	endtask

	// sticky flag set and release
	task automatic pulse(int idx);
		pin_next[idx] = 1'b1;
		idle(4);
		pin_next[idx] = 1'b0;
		idle(4);
		case (idx)
			PIN_STEP:    sticky_q[MCF_STEP] = 1'b1;
			PIN_OTHER:   sticky_q[MCF_STEP] = 1'b0;
			PIN_SELECT:  sticky_q[MCF_ATTN] = 1'b1;
			PIN_ADDRESS: sticky_q[MCF_ATTN] = 1'b0;
			PIN_TIMEOUT: sticky_q[MCF_TIMEOUT] = 1'b1;
			PIN_MEM_HI:  sticky_q[MCF_MEM_HI] = 1'b1;
			PIN_MEM_LO:  sticky_q[MCF_MEM_LO] = 1'b1;
			PIN_POWER:   sticky_q[MCF_POWER] = 1'b1;
			default:     sticky_q = sticky_q;
		endcase
		sense();
	endtask

	task automatic random_ops(int n);
		repeat (n) step($urandom_range(0, 3) != 0, bsmc_op_type'($urandom_range(0, 9)), $urandom, $urandom,
			1'($urandom_range(0, 1)));
	endtask

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (8000) @(posedge core_clk);
		error_cnt++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst       = 1'b1;
		req_v     = 1'b0;
		req_op    = BSMC_NONE;
		req_a     = WORD_ZERO;
		req_b     = WORD_ZERO;
		req_ma    = 1'b0;
		pins      = '0;
		pin_next  = '0;
		sticky_q  = MCR_RESET;
		e_s       = WORD_ZERO;
		e_valid   = 1'b0;
		e_cc      = CC_ZERO;
		e_micro   = CC_ZERO;
		e_wait    = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		void'($urandom(32'hb965));
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		idle(4);
		sense();
		random_ops(100);
		// every pin from power warning down to single step, drop switches included, then step and select again
		foreach (pins[i])
			if (i >= PIN_STEP)
				pulse(i);
		pulse(PIN_STEP);
		pulse(PIN_SELECT);
		// clear everything back to back with a sense, then re-raise
		step(1'b1, BSMC_CLEAR_CONTROL_FLAGS, WORD_ZERO, 32'hffff_ffff, 1'b0);
		sense();
		pulse(PIN_POWER);
		pulse(PIN_MEM_HI);
		// straps and panel initialise held high
		pin_next[PIN_FLOAT]   = 1'b1;
		pin_next[PIN_CRC]     = 1'b1;
		pin_next[PIN_RESTART] = 1'b1;
		pin_next[PIN_INIT]    = 1'b1;
		idle(4);
		step(1'b1, BSMC_CLEAR_CONTROL_FLAGS, WORD_ZERO, 32'h0000_ffff, 1'b0);
		sense();
		step(1'b1, BSMC_LOAD_WAIT_LATCH, WORD_ZERO, 32'h0000_8000, 1'b0);
		step(1'b1, BSMC_LOAD_WAIT_LATCH, WORD_ZERO, 32'hffff_7fff, 1'b0);
		random_ops(150);
		pin_next[PIN_INIT] = 1'b0;
		pulse(PIN_TIMEOUT);
		random_ops(150);
		idle(2);
		complete_run();
	end
endmodule
